// ==== srs_mgmt_model.sv ====
`timescale 1ns/100ps
// ------------------------------
// management requester model
// ------------------------------
module srs_mgmt_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // bench control
  input wire logic go_i,
  input wire logic [7:0] cond_i,
  // readout side
  output logic req_o,
  input wire logic resp_valid_i,
  input wire srs_pkg::srs_resp_t resp_i,
  // captured answer and how far it may be trusted
  output srs_pkg::srs_resp_t cap_o,
  output logic got_o,
  output logic use_state_o,
  output logic use_reading_o,
  output logic signed_o
);
  // one request per bench command; answer kept until the next one
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_o <= 1'b0;
      got_o <= 1'b0;
      cap_o <= '0;
    end else begin
      req_o <= go_i;
      got_o <= resp_valid_i;
      if (resp_valid_i) begin
        cap_o <= resp_i;
      end
    end
  end

  // state fields mean nothing unless enabled, initializing included
  assign use_state_o = cond_i == srs_pkg::OC_ENABLED;
  assign use_reading_o = cond_i != srs_pkg::OC_UNAVAILABLE;
  assign signed_o = cap_o.sample_width_code[0];
endmodule

// ==== srs_pkg.sv ====
package srs_pkg;

  // ----------------------------------------------------------------
  // state codes shared by current, prior and threshold event fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_UNKNOWN = 8'h00;
  localparam logic [7:0] ST_NORMAL = 8'h01;
  localparam logic [7:0] ST_WARNING = 8'h02;
  localparam logic [7:0] ST_CRITICAL = 8'h03;
  localparam logic [7:0] ST_FATAL = 8'h04;
  localparam logic [7:0] ST_LOWER_WARNING = 8'h05;
  localparam logic [7:0] ST_LOWER_CRITICAL = 8'h06;
  localparam logic [7:0] ST_LOWER_FATAL = 8'h07;
  localparam logic [7:0] ST_UPPER_WARNING = 8'h08;
  localparam logic [7:0] ST_UPPER_CRITICAL = 8'h09;
  localparam logic [7:0] ST_UPPER_FATAL = 8'h0A;

  // ----------------------------------------------------------------
  // operating condition codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OC_ENABLED = 8'h00;
  localparam logic [7:0] OC_DISABLED = 8'h01;
  localparam logic [7:0] OC_UNAVAILABLE = 8'h02;
  localparam logic [7:0] OC_STATUS_UNKNOWN = 8'h03;
  localparam logic [7:0] OC_FAILED = 8'h04;
  localparam logic [7:0] OC_INITIALIZING = 8'h05;
  localparam logic [7:0] OC_SHUTTING_DOWN = 8'h06;
  localparam logic [7:0] OC_IN_TEST = 8'h07;

  // ----------------------------------------------------------------
  // sample width codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SW_UINT8 = 3'h0;
  localparam logic [2:0] SW_SINT8 = 3'h1;
  localparam logic [2:0] SW_UINT16 = 3'h2;
  localparam logic [2:0] SW_SINT16 = 3'h3;
  localparam logic [2:0] SW_UINT32 = 3'h4;
  localparam logic [2:0] SW_SINT32 = 3'h5;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_READING = 8'h10;
  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_DEMAND_BIT = 3;
  localparam logic [2:0] CTRL_WIDTH_RESET = 3'h4;
  localparam int NUM_EVENTS = 3;
  localparam int EV_STATE_CHANGE = 0;
  localparam int EV_EVENT_CHANGE = 1;
  localparam int EV_COND_CHANGE = 2;
  localparam logic [NUM_EVENTS-1:0] MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_CNT_W = 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] state;
    logic [7:0] event_code;
  } srs_assess_t;

  typedef struct packed {
    logic [7:0] current_state_code;
    logic [7:0] prior_state_code;
    logic [7:0] threshold_event_code;
    logic [31:0] latest_measurement;
    logic [2:0] sample_width_code;
  } srs_resp_t;

endpackage

// ==== srs_readout_properties.sv ====
`timescale 1ns/100ps
// ------------------------------
// response field checker
// ------------------------------
module srs_readout_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // sensor side
  input wire logic [7:0] operating_condition_i,
  input wire logic [31:0] sample_i,
  input wire logic assess_valid_i,
  input wire srs_pkg::srs_assess_t assess_i,
  // request side
  input wire logic req_i,
  input wire logic resp_valid_o,
  input wire srs_pkg::srs_resp_t resp_o,
  // register port and interrupt
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_o
);
  localparam logic [7:0] U = srs_pkg::ST_UNKNOWN;
  localparam logic [7:0] TOP = srs_pkg::ST_UPPER_FATAL;
  logic en;
  logic cur_seen;
  logic evt_seen;
  logic prior_seen;
  logic [7:0] last;
  logic [7:0] left;
  logic [7:0] cur;
  logic [7:0] pri;
  logic [7:0] evt;
  logic [31:0] meas;
  logic [2:0] wid;

  assign en = operating_condition_i == srs_pkg::OC_ENABLED;
  assign cur = resp_o.current_state_code;
  assign pri = resp_o.prior_state_code;
  assign evt = resp_o.threshold_event_code;
  assign meas = resp_o.latest_measurement;
  assign wid = resp_o.sample_width_code;

  // what the readout may claim; forgotten whenever not enabled
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_seen <= 1'b0;
      evt_seen <= 1'b0;
      prior_seen <= 1'b0;
      last <= U;
      left <= U;
    end else if (!en) begin
      cur_seen <= 1'b0;
      evt_seen <= 1'b0;
      prior_seen <= 1'b0;
      last <= U;
    end else if (assess_valid_i) begin
      if (assess_i.state != U) begin
        cur_seen <= 1'b1;
        last <= assess_i.state;
        if (cur_seen && assess_i.state != last) begin
          prior_seen <= 1'b1;
          left <= last;
        end
      end
      if (assess_i.event_code != U && assess_i.event_code <= TOP) begin
        evt_seen <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // a response reflects the condition sampled at its request edge
  cur_known_a:
    assert property (resp_valid_o && $past(en && cur_seen) |-> cur != U)
    else $error("current state unknown while enabled");
  cur_gated_a:
    assert property (resp_valid_o && !$past(en) |-> cur == U)
    else $error("current state reported while not enabled");
  prior_differs_a:
    assert property (resp_valid_o |-> pri != cur || cur == U)
    else $error("prior state equals current state");
  prior_left_a:
    assert property (resp_valid_o && $past(en && prior_seen)
      |-> pri == $past(left))
    else $error("prior state is not the state left");
  prior_gated_a:
    assert property (resp_valid_o && !$past(en) |-> pri == U)
    else $error("prior state reported while not enabled");
  codes_defined_a:
    assert property (resp_valid_o |-> cur <= TOP && pri <= TOP && evt <= TOP)
    else $error("state field outside the enumeration");
  evt_known_a:
    assert property (resp_valid_o && $past(en && evt_seen) |-> evt != U)
    else $error("event code unknown after assessment");
  evt_gated_a:
    assert property (resp_valid_o && !$past(en) |-> evt == U)
    else $error("event code reported while not enabled");
  narrow_zero_a:
    assert property (resp_valid_o && wid == srs_pkg::SW_UINT8
      |-> meas[31:8] == 24'h00_0000)
    else $error("unsigned byte reading not zero extended");
  narrow_sign_a:
    assert property (resp_valid_o && wid == srs_pkg::SW_SINT8
      |-> meas[31:8] == {24{meas[7]}})
    else $error("signed byte reading not sign extended");
  off_quiet_a:
    assert property (resp_valid_o
      && $past(operating_condition_i) == srs_pkg::OC_DISABLED
      |-> meas == 32'h0000_0000)
    else $error("reading supplied while disabled");

  // main scenarios reached
  known_resp_c: cover property (resp_valid_o && cur != U && pri != U);
  irq_rise_c: cover property ($rose(irq_o));
  neg_byte_c: cover property (resp_valid_o && wid == 3'h1 && meas[7]);
endmodule

// ==== srs_sample_fmt.sv ====
`timescale 1ns/100ps
// fits a raw sample to the selected width, extending sign or zero
module srs_sample_fmt (
  // raw sample and width selection
  input wire logic [31:0] raw_i,
  input wire logic [2:0] width_i,
  // formatted value
  output logic [31:0] value_o
);

  // unknown width codes fall back to full 32 bits
  always_comb begin
    case (width_i)
      srs_pkg::SW_UINT8: value_o = {24'h00_0000, raw_i[7:0]};
      srs_pkg::SW_SINT8: value_o = {{24{raw_i[7]}}, raw_i[7:0]};
      srs_pkg::SW_UINT16: value_o = {16'h0000, raw_i[15:0]};
      srs_pkg::SW_SINT16: value_o = {{16{raw_i[15]}}, raw_i[15:0]};
      default: value_o = raw_i;
    endcase
  end

endmodule

// ==== srs_sensor_readout.sv ====
// Notes on behaviour
// - while enabled the current state code is Unknown only until first assessed
// - not enabled reports Unknown current state; requester ignores it
// - prior state always differs from current unless both are Unknown
// - a changed assessment loads prior with the state being left
// - prior may be Unknown only until the current state first changes
// - not enabled reports Unknown prior state; requester ignores it
// - threshold event code is always a defined code
// - event code may be Unknown only until first assessed
// - event code is Unknown whenever not enabled
// - all three fields share one 8-bit state enumeration
// - reading width and sign follow the sample width code; a held periodic reading keeps the width it was captured with
// - reading is a periodic sample or taken at request time
// - reading need not be correct while unavailable
// - disabled condition stops supplying reading and event values
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module srs_sensor_readout (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // operating condition and raw sample
  input wire logic [7:0] operating_condition_i,
  input wire logic [31:0] sample_i,
  // assessment stage
  input wire logic assess_valid_i,
  input wire srs_pkg::srs_assess_t assess_i,
  // reading request and response
  input wire logic req_i,
  output logic resp_valid_o,
  output srs_pkg::srs_resp_t resp_o,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int SRS_W = srs_pkg::SAMPLE_CNT_W;
  localparam logic [SRS_W-1:0] SAMPLE_LAST =
    SRS_W'(srs_pkg::SAMPLE_CYCLES - 1);
  logic enabled;
  logic supplies;
  logic [7:0] cur;
  logic [7:0] next_cur;
  logic [7:0] prior;
  logic [7:0] next_prior;
  logic [7:0] evt;
  logic [7:0] next_evt;
  logic [7:0] last_cond;
  logic [7:0] next_last_cond;
  logic state_chg;
  logic evt_chg;
  logic cond_chg;
  logic [SRS_W-1:0] sample_cnt;
  logic [SRS_W-1:0] next_sample_cnt;
  logic [31:0] meas;
  logic [31:0] next_meas;
  logic [31:0] fmt_value;
  logic [2:0] width_code;
  logic [2:0] next_width_code;
  logic on_demand;
  logic next_on_demand;
  logic [srs_pkg::NUM_EVENTS-1:0] mask;
  logic [srs_pkg::NUM_EVENTS-1:0] next_mask;
  logic [srs_pkg::NUM_EVENTS-1:0] status;
  logic [srs_pkg::NUM_EVENTS-1:0] ev_set;
  logic [srs_pkg::NUM_EVENTS-1:0] ev_clr;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  srs_pkg::srs_resp_t resp;
  srs_pkg::srs_resp_t next_resp;
  logic resp_valid;
  logic next_resp_valid;

  // only the enabled condition lets state fields through
  assign enabled = (operating_condition_i == srs_pkg::OC_ENABLED);
  // disabled stops the reading; unavailable keeps it but it is ignored
  assign supplies = (operating_condition_i != srs_pkg::OC_DISABLED);

  // ----------------------------------------------------------------
  // state tracking from the assessment stage
  // ----------------------------------------------------------------

  // an Unknown assessment is dropped so enabled fields never fall back
  always_comb begin
    next_cur = cur;
    next_prior = prior;
    next_evt = evt;
    state_chg = 1'b0;
    evt_chg = 1'b0;
    if (!enabled) begin
      next_cur = srs_pkg::ST_UNKNOWN;
      next_prior = srs_pkg::ST_UNKNOWN;
      next_evt = srs_pkg::ST_UNKNOWN;
    end else if (assess_valid_i) begin
      if (assess_i.state != srs_pkg::ST_UNKNOWN &&
          assess_i.state != cur) begin
        next_cur = assess_i.state;
        if (cur != srs_pkg::ST_UNKNOWN) begin
          next_prior = cur;
          state_chg = 1'b1;
        end
      end
      if (assess_i.event_code != srs_pkg::ST_UNKNOWN &&
          assess_i.event_code <= srs_pkg::ST_UPPER_FATAL) begin
        next_evt = assess_i.event_code;
        evt_chg = (assess_i.event_code != evt);
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur <= srs_pkg::ST_UNKNOWN;
      prior <= srs_pkg::ST_UNKNOWN;
      evt <= srs_pkg::ST_UNKNOWN;
    end else begin
      cur <= next_cur;
      prior <= next_prior;
      evt <= next_evt;
    end
  end

  // ----------------------------------------------------------------
  // operating condition change detection
  // ----------------------------------------------------------------

  // reset value is disabled so that a first enable raises an event
  always_comb begin
    next_last_cond = operating_condition_i;
    cond_chg = (operating_condition_i != last_cond);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      last_cond <= srs_pkg::OC_DISABLED;
    end else begin
      last_cond <= next_last_cond;
    end
  end

  // ----------------------------------------------------------------
  // measurement sampling
  // ----------------------------------------------------------------
  srs_sample_fmt u_fmt (
    .raw_i(sample_i),
    .width_i(width_code),
    .value_o(fmt_value)
  );

  // periodic capture holds the value used when on-demand sampling is off
  always_comb begin
    next_sample_cnt = sample_cnt;
    next_meas = meas;
    if (!supplies) begin
      next_sample_cnt = '0;
      next_meas = 32'h0000_0000;
    end else if (sample_cnt == SAMPLE_LAST) begin
      next_sample_cnt = '0;
      next_meas = fmt_value;
    end else begin
      next_sample_cnt = sample_cnt + SRS_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sample_cnt <= '0;
      meas <= 32'h0000_0000;
    end else begin
      sample_cnt <= next_sample_cnt;
      meas <= next_meas;
    end
  end

  // ----------------------------------------------------------------
  // reading response
  // ----------------------------------------------------------------

  // fields are gated by the live condition, so a stale register never
  // leaks out in the cycle that enable drops
  always_comb begin
    next_resp = resp;
    next_resp_valid = req_i;
    if (req_i) begin
      next_resp.current_state_code =
        enabled ? cur : srs_pkg::ST_UNKNOWN;
      next_resp.prior_state_code =
        enabled ? prior : srs_pkg::ST_UNKNOWN;
      next_resp.threshold_event_code =
        enabled ? evt : srs_pkg::ST_UNKNOWN;
      if (!supplies) begin
        next_resp.latest_measurement = 32'h0000_0000;
      end else if (on_demand) begin
        next_resp.latest_measurement = fmt_value;
      end else begin
        next_resp.latest_measurement = meas;
      end
      next_resp.sample_width_code = width_code;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      resp <= '0;
      resp_valid <= 1'b0;
    end else begin
      resp <= next_resp;
      resp_valid <= next_resp_valid;
    end
  end

  assign resp_o = resp;
  assign resp_valid_o = resp_valid;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------

  // width change affects the next captured sample, not the held one
  always_comb begin
    next_width_code = width_code;
    next_on_demand = on_demand;
    next_mask = mask;
    if (wr_i && addr_i == srs_pkg::ADDR_CTRL) begin
      next_width_code = wdata_i[srs_pkg::CTRL_WIDTH_LSB +: 3];
      next_on_demand = wdata_i[srs_pkg::CTRL_DEMAND_BIT];
    end
    if (wr_i && addr_i == srs_pkg::ADDR_MASK) begin
      next_mask = wdata_i[srs_pkg::NUM_EVENTS-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      width_code <= srs_pkg::CTRL_WIDTH_RESET;
      on_demand <= 1'b0;
      mask <= srs_pkg::MASK_RESET;
    end else begin
      width_code <= next_width_code;
      on_demand <= next_on_demand;
      mask <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    ev_set = '0;
    ev_set[srs_pkg::EV_STATE_CHANGE] = state_chg;
    ev_set[srs_pkg::EV_EVENT_CHANGE] = evt_chg;
    ev_set[srs_pkg::EV_COND_CHANGE] = cond_chg;
    ev_clr = '0;
    if (wr_i && addr_i == srs_pkg::ADDR_STATUS) begin
      ev_clr = wdata_i[srs_pkg::NUM_EVENTS-1:0];
    end
  end

  srs_sticky #(
    .W(srs_pkg::NUM_EVENTS)
  ) u_status (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .set_i(ev_set),
    .clr_i(ev_clr),
    .flags_o(status)
  );

  assign irq_o = |(status & mask);

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------

  // data stands only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        srs_pkg::ADDR_CTRL: begin
          next_rdata[srs_pkg::CTRL_WIDTH_LSB +: 3] = width_code;
          next_rdata[srs_pkg::CTRL_DEMAND_BIT] = on_demand;
        end
        srs_pkg::ADDR_STATUS: begin
          next_rdata[srs_pkg::NUM_EVENTS-1:0] = status;
        end
        srs_pkg::ADDR_MASK: begin
          next_rdata[srs_pkg::NUM_EVENTS-1:0] = mask;
        end
        srs_pkg::ADDR_STATE: begin
          next_rdata = {operating_condition_i,
                        enabled ? evt : srs_pkg::ST_UNKNOWN,
                        enabled ? prior : srs_pkg::ST_UNKNOWN,
                        enabled ? cur : srs_pkg::ST_UNKNOWN};
        end
        srs_pkg::ADDR_READING: begin
          next_rdata = meas;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;

endmodule

// ==== srs_sticky.sv ====
`timescale 1ns/100ps
// sticky status bits, write one to clear; a set in the clear cycle wins
module srs_sticky #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // event and clear
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // state
  output logic [W-1:0] flags_o
);

  logic [W-1:0] flags;
  logic [W-1:0] next_flags;

  // set takes priority so an event in the clear cycle is kept
  always_comb begin
    next_flags = (flags & ~clr_i) | set_i;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  assign flags_o = flags;

endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
// ------------------------------
// readout testbench
// ------------------------------
module tb_top;
  typedef struct packed {
    logic [2:0] w;
    logic [31:0] s;
    logic [31:0] e;
  } srs_row_t;
  logic clk_i;
  logic reset_i;
  logic [7:0] cond;
  logic [31:0] sample;
  logic av;
  srs_pkg::srs_assess_t as;
  logic req;
  logic rv;
  logic go;
  logic got;
  srs_pkg::srs_resp_t resp;
  srs_pkg::srs_resp_t cap;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr;
  logic rd;
  logic irq;
  logic use_st;
  logic use_rd;
  logic sgn;
  int errors;
  int checks_done;
  srs_row_t rows [7];

  srs_sensor_readout dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .operating_condition_i(cond), .sample_i(sample), .assess_valid_i(av),
    .assess_i(as), .req_i(req), .resp_valid_o(rv), .resp_o(resp),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq));
  srs_mgmt_model mgr_u (.clk_i(clk_i), .reset_i(reset_i), .go_i(go),
    .cond_i(cond), .req_o(req), .resp_valid_i(rv), .resp_i(resp),
    .cap_o(cap), .got_o(got), .use_state_o(use_st),
    .use_reading_o(use_rd), .signed_o(sgn));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic setc(input logic [7:0] c);
    @(posedge clk_i);
    cond <= c;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic assess(input logic [7:0] s, input logic [7:0] ev);
    @(posedge clk_i);
    av <= 1'b1;
    as <= '{s, ev};
    @(posedge clk_i);
    av <= 1'b0;
  endtask
  // bounded wait: the answer lands two edges after the request
  task automatic ask;
    int n;
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    while (got !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({31'h0, got}, 32'h1);
  endtask
  task automatic fields(input logic [7:0] c, p, e);
    chk({8'h0, cap.current_state_code, cap.prior_state_code,
      cap.threshold_event_code}, {8'h0, c, p, e});
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog well beyond the roughly 300 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    results();
  end

  // main sequence
  initial begin
    reset_i = 1'b1;
    cond = srs_pkg::OC_DISABLED;
    sample = 32'h0;
    av = 1'b0;
    as = '0;
    go = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    errors = 0;
    checks_done = 0;
    rows = '{'{3'h0, 32'h1234_5680, 32'h0000_0080},
      '{3'h1, 32'h1234_5680, 32'hFFFF_FF80},
      '{3'h1, 32'h0000_007F, 32'h0000_007F},
      '{3'h2, 32'h1234_8001, 32'h0000_8001},
      '{3'h3, 32'h1234_8001, 32'hFFFF_8001},
      '{3'h4, 32'h8765_4321, 32'h8765_4321},
      '{3'h5, 32'h8765_4321, 32'h8765_4321}};
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rd_reg(srs_pkg::ADDR_CTRL, 32'h0000_0004);
    rd_reg(srs_pkg::ADDR_MASK, 32'h0000_0000);
    rd_reg(srs_pkg::ADDR_STATUS, 32'h0000_0000);
    rd_reg(8'h14, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    setc(srs_pkg::OC_ENABLED);
    assess(8'h01, 8'h01);
    ask();
    fields(8'h01, 8'h00, 8'h01);
    assess(8'h02, 8'h08);
    assess(8'h02, 8'h08);
    ask();
    fields(8'h02, 8'h01, 8'h08);
    assess(8'h03, 8'h08);
    assess(8'h00, 8'h0B);
    ask();
    fields(8'h03, 8'h02, 8'h08);
    rd_reg(srs_pkg::ADDR_STATE, 32'h0008_0203);
    wr_reg(srs_pkg::ADDR_STATE, 32'hFFFF_FFFF);
    rd_reg(srs_pkg::ADDR_STATE, 32'h0008_0203);
    // interrupt: raise through the mask, then clear by writing one
    rd_reg(srs_pkg::ADDR_STATUS, 32'h0000_0007);
    chk({31'h0, irq}, 32'h0);
    wr_reg(srs_pkg::ADDR_MASK, 32'h0000_0001);
    chk({31'h0, irq}, 32'h1);
    wr_reg(srs_pkg::ADDR_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0);
    rd_reg(srs_pkg::ADDR_STATUS, 32'h0000_0006);
    // widths sampled on demand
    foreach (rows[i]) begin
      @(posedge clk_i);
      sample <= rows[i].s;
      wr_reg(srs_pkg::ADDR_CTRL, {28'h0, 1'b1, rows[i].w});
      ask();
      chk(cap.latest_measurement, rows[i].e);
      chk({29'h0, cap.sample_width_code}, {29'h0, rows[i].w});
      chk({31'h0, sgn}, {31'h0, rows[i].w[0]});
    end
    // periodic sampling: wait past one 50 cycle period
    wr_reg(srs_pkg::ADDR_CTRL, 32'h0000_0004);
    @(posedge clk_i);
    sample <= 32'h1357_9BDF;
    repeat (60) @(posedge clk_i);
    ask();
    chk(cap.latest_measurement, 32'h1357_9BDF);
    rd_reg(srs_pkg::ADDR_READING, 32'h1357_9BDF);
    // every other condition: fields unknown, assessments ignored
    for (int c = 1; c < 8; c++) begin
      setc(c[7:0]);
      assess(8'h04, 8'h04);
      ask();
      fields(8'h00, 8'h00, 8'h00);
      chk({30'h0, use_st, use_rd}, {30'h0, 1'b0, c != 2});
      if (c == 1) begin
        chk(cap.latest_measurement, 32'h0);
      end
    end
    setc(srs_pkg::OC_ENABLED);
    ask();
    fields(8'h00, 8'h00, 8'h00);
    // walk the state enumeration from Normal to Upper Fatal
    for (int s = 1; s < 11; s++) begin
      assess(s[7:0], s[7:0]);
      ask();
      fields(s[7:0], (s == 1) ? 8'h00 : 8'(s - 1), s[7:0]);
    end
    // reset again mid-run: outputs quiet, control back to its reset value, status showing the condition change event
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk(rdata, 32'h0);
    chk({30'h0, rv, irq}, 32'h0);
    @(posedge clk_i);
    reset_i <= 1'b0;
    rd_reg(srs_pkg::ADDR_CTRL, 32'h0000_0004);
    rd_reg(srs_pkg::ADDR_STATUS, 32'h0000_0004);
    ask();
    fields(8'h00, 8'h00, 8'h00);
    results();
  end
endmodule

bind srs_sensor_readout srs_readout_props chk_u (.clk_i(clk_i),
  .reset_i(reset_i), .operating_condition_i(operating_condition_i),
  .sample_i(sample_i), .assess_valid_i(assess_valid_i),
  .assess_i(assess_i), .req_i(req_i), .resp_valid_o(resp_valid_o),
  .resp_o(resp_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
